//--- dv/tb_top.sv
// Self-checking bench for the watch and buzzer block
`timescale 1ns/1ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin failCount++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top
	import watch_pkg::*;
;
	logic mclk = 1'b0, rst = 1'b1, clkEn = 1'b1, wr = 1'b0, rd = 1'b0;
	logic slowClock = 1'b0, portData = 1'b0, hourTick = 1'b0, lastTone = 1'b0;
	logic slowStop = 1'b0;
	int sCnt = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
	logic tonePin, minuteTick, secondTick, watchIrq, irq;
	int failCount = 0, samplesChecked = 0, wCnt = 0, mCnt = 0, togCnt = 0, e, w;
	int seed = 40654;
	always #2.5 mclk = ~mclk;
	watch_buzzer_second_counter dut (.mclk(mclk), .rst(rst), .clkEn(clkEn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .slowClock(slowClock),
		.slowClockStop(slowStop), .portData(portData), .tonePin(tonePin), .hourTick(hourTick),
		.minuteTick(minuteTick), .secondTick(secondTick), .watchIrq(watchIrq), .irq(irq));
	////////////////////////////////////////////////////////////////
	// Pulse and toggle counters, random port data
	always @(posedge mclk) begin
		wCnt += (watchIrq === 1'b1);
		mCnt += (minuteTick === 1'b1);
		sCnt += (secondTick === 1'b1);
		togCnt += (tonePin !== lastTone);
		lastTone = tonePin;
		portData <= $random(seed);
	end
	// Expected readback and tone toggles per 64 slow edges
	function automatic logic [7:0] ctrlView(input logic [7:0] v);
		return v & 8'he6;
	endfunction
	function automatic int toneEdges(input int s);
		return (s == 0) ? 0 : (4 << (s - 1));
	endfunction
	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rdReg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		got = rdata;
	endtask
	// Slow clock runs only while pulses are asked for
	task automatic slowPulses(input int n);
		repeat (n) begin
			@(posedge mclk);
			slowClock <= 1'b1;
			repeat (4) @(posedge mclk);
			slowClock <= 1'b0;
			repeat (3) @(posedge mclk);
		end
		repeat (8) @(posedge mclk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#400000;
		failCount++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rdReg(CONTROL_OFFSET);
		`CHK("control reset", CONTROL_RESET, got)
		rdReg(SECOND_OFFSET);
		`CHK("second reset", SECOND_RESET, got)
		wrReg(8'ha5, 8'hff);
		rdReg(8'ha5);
		`CHK("unmapped", 8'h00, got)
		repeat (8) begin
			e = $random(seed);
			wrReg(CONTROL_OFFSET, e[7:0]);
			rdReg(CONTROL_OFFSET);
			`CHK("control", ctrlView(e[7:0]), got)
			e = {$random(seed)} % 60;
			wrReg(SECOND_OFFSET, 8'h80 | e[7:0]);
			repeat (4) @(posedge mclk);
			rdReg(SECOND_OFFSET);
			`CHK("second halted", 8'h80 | e[7:0], got)
		end
		// Test mode count across the wrap, minute source unmasked
		wrReg(CONTROL_OFFSET, 8'h04);
		wrReg(IRQ_MASK_OFFSET, 8'h02);
		wrReg(SECOND_OFFSET, 8'h7a);
		slowPulses(1);
		rdReg(SECOND_OFFSET);
		`CHK("test step", 8'h7b, got)
		e = mCnt;
		w = wCnt;
		slowPulses(1);
		rdReg(SECOND_OFFSET);
		`CHK("wrap", 8'h40, got)
		`CHK("minute tick", e + 1, mCnt)
		`CHK("minute irq", w + 1, wCnt)
		`CHK("irq on", 1'b1, irq)
		wrReg(SECOND_OFFSET, 8'ha0);
		wrReg(IRQ_STATUS_OFFSET, 8'h0f);
		repeat (3) @(negedge mclk);
		`CHK("irq cleared", 1'b0, irq)
		// Software write makes count bit 5 fall
		wrReg(CONTROL_OFFSET, 8'h02);
		w = wCnt;
		wrReg(SECOND_OFFSET, 8'h80);
		repeat (3) @(negedge mclk);
		`CHK("bit5 fall irq", w + 1, wCnt)
		rdReg(IRQ_STATUS_OFFSET);
		`CHK("status", 8'h01, got & 8'h01)
		// Hour tick reaches the watch irq only with select 11
		for (int s = 0; s < 4; s++) begin
			wrReg(CONTROL_OFFSET, {5'h00, s[1:0], 1'b0});
			w = wCnt;
			@(posedge mclk);
			hourTick <= 1'b1;
			@(posedge mclk);
			hourTick <= 1'b0;
			repeat (3) @(negedge mclk);
			`CHK("hour route", w + (s == 3), wCnt)
		end
		// Tone toggles over 64 slow edges for each select code
		for (int s = 0; s < 4; s++) begin
			wrReg(CONTROL_OFFSET, {1'b1, s[1:0], 5'h00});
			repeat (4) @(posedge mclk);
			togCnt = 0;
			slowPulses(64);
			`CHK("tone toggles", toneEdges(s), togCnt)
			if (s == 0) `CHK("tone low", 1'b0, tonePin)
		end
		// One second of fast slow clock in normal mode, prescaler cleared first
		wrReg(CONTROL_OFFSET, 8'h0a);
		wrReg(SECOND_OFFSET, 8'h05);
		e = sCnt;
		w = wCnt;
		repeat (32768) begin
			@(posedge mclk);
			slowClock <= 1'b1;
			@(posedge mclk);
			slowClock <= 1'b0;
		end
		repeat (8) @(posedge mclk);
		`CHK("second tick", e + 1, sCnt)
		`CHK("second irq", w + 1, wCnt)
		rdReg(SECOND_OFFSET);
		`CHK("second step", 8'h06, got)
		// Stop input and clear bit both zero the prescaler
		wrReg(CONTROL_OFFSET, 8'he0);
		slowPulses(5);
		`CHK("tone before stop", 1'b1, tonePin)
		@(posedge mclk);
		slowStop <= 1'b1;
		repeat (4) @(posedge mclk);
		slowStop <= 1'b0;
		repeat (6) @(negedge mclk);
		`CHK("stop clears", 1'b0, tonePin)
		slowPulses(4);
		`CHK("tone before clear", 1'b1, tonePin)
		wrReg(CONTROL_OFFSET, 8'he8);
		repeat (3) @(negedge mclk);
		`CHK("clear bit", 1'b0, tonePin)
		report_and_stop();
	end
endmodule

//--- dv/watch_buzzer_chk.sv
// Port checker for the watch and buzzer block
`timescale 1ns/1ps
module watch_buzzer_chk
	import watch_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// Pins and ticks
	input wire logic slowClock,
	input wire logic slowClockStop,
	input wire logic portData,
	input wire logic tonePin,
	input wire logic hourTick,
	input wire logic minuteTick,
	input wire logic secondTick,
	input wire logic watchIrq,
	input wire logic irq
);
	logic [7:0] ctrlCopy_reg;
	logic [7:0] ctrlCopy_next;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Shadow of the control register from accepted writes
	always_comb begin
		ctrlCopy_next = ctrlCopy_reg;
		if (clkEn && wr && addr == CONTROL_OFFSET) begin
			ctrlCopy_next = wdata;
		end
	end
	always_ff @(posedge mclk) begin
		ctrlCopy_reg <= rst ? CONTROL_RESET : ctrlCopy_next;
	end
	////////////////////////////////////////////////////////////////
	// Steps of the checked behaviours
	sequence hourPicked;
		hourTick && clkEn && ctrlCopy_reg[2:1] == WSRC_HOUR;
	endsequence
	sequence ctrlRead;
		rd && clkEn && addr == CONTROL_OFFSET;
	endsequence
	chk_pin_port: assert property (
		!$past(rst) && $past(clkEn) && $stable(ctrlCopy_reg) && !ctrlCopy_reg[7]
		|-> tonePin == $past(portData)) else $error("shared pin not port");
	chk_tone_low: assert property (
		!$past(rst) && $past(clkEn) && $stable(ctrlCopy_reg) && ctrlCopy_reg[7:5] == 3'h4
		|-> !tonePin) else $error("tone not held low");
	chk_irq_none: assert property (
		ctrlCopy_reg[2:1] == WSRC_NONE && $past(ctrlCopy_reg[2:1]) == WSRC_NONE
		&& $past(ctrlCopy_reg[2:1], 2) == WSRC_NONE |-> !watchIrq) else $error("irq with none");
	chk_hour_route: assert property (
		hourPicked |=> watchIrq) else $error("hour tick not routed");
	chk_watch_pulse: assert property (
		watchIrq && clkEn |=> !watchIrq) else $error("watch irq too long");
	chk_clear_read: assert property (
		ctrlRead |=> rdata[CLEAR_BIT] == 1'b0 && rdata[0] == 1'b0) else $error("clear bit read 1");
	chk_rdata_idle: assert property (
		!$past(rst) && $past(clkEn) && !$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
	chk_minute_pulse: assert property (
		minuteTick && clkEn |=> !minuteTick) else $error("minute tick too long");
endmodule
bind watch_buzzer_second_counter watch_buzzer_chk chkInst (.mclk(mclk), .rst(rst),
	.clkEn(clkEn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.slowClock(slowClock), .slowClockStop(slowClockStop), .portData(portData),
	.tonePin(tonePin), .hourTick(hourTick), .minuteTick(minuteTick),
	.secondTick(secondTick), .watchIrq(watchIrq), .irq(irq));

//--- rtl/slow_prescaler.sv
// Slow clock prescaler: 17-bit counter advanced on sampled slow clock edges
`timescale 1ns/1ps
module slow_prescaler
	import watch_pkg::*;
#(
	parameter int WIDTH = PRESCALER_WIDTH
) (
	// Clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	// Count control
	input wire logic slowEdge,
	input wire logic clear,
	// Results
	output logic [WIDTH-1:0] count,
	output logic secondTick,
	output logic twoSecondTick
);
	logic [WIDTH-1:0] count_reg, count_next;

	// Next count and tick decode
	always_comb begin
		count_next = count_reg;
		secondTick = 1'b0;
		twoSecondTick = 1'b0;
		if (clear) begin
			count_next = '0;
		end else if (slowEdge) begin
			count_next = count_reg + 1'b1;
			// One second is 2^15 slow edges, two seconds 2^16
			secondTick = (count_next[WIDTH-3:0] == '0);
			twoSecondTick = (count_next[WIDTH-2:0] == '0);
		end
	end

	// Count register
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_reg <= '0;
		end else if (clkEn) begin
			count_reg <= count_next;
		end
	end

	assign count = count_reg;
endmodule

//--- rtl/watch_buzzer_second_counter.sv
// Watch and buzzer control with modulo-60 second counter
`timescale 1ns/1ps
// How it works
// [R01] Shared pin goes to general port when pin enable is 0, tone when 1.
// [R02] Tone select 00 holds the tone output low.
// [R03] Tone select 01/10/11 gives 1.024/2.048/4.096 kHz square waves.
// [R04] Read-only stable flag, 0 after reset, 1 when slow clock may be stable.
// [R05] Writing 1 to clear bit zeroes the prescaler and stable flag.
// [R06] Writing 0 to clear bit does nothing; it always reads 0.
// [R07] Watch irq select: none, second, minute or hour tick.
// [R08] Halt bit resets to 1 and stops the second counter; 0 runs it.
// [R09] Test bit 0 counts seconds; 1 counts every slow clock cycle.
// [R10] Software sets test bit only in fast clock modes.
// [R11] Six-bit second count wraps from 3b to 00.
// [R12] Second counter wrap gives the one-minute tick.
// [R13] Select 01 and count bit 5 falling raises an interrupt.
// [R14] Count is software writable, resets to zero, updated by hardware.
// [R15] Prescaler counts slow clock, cleared by reset, stop or clear bit.
// [R16] Stable flag set two seconds after start, cleared by reset or stop.
// [R17] Minute counter outside uses minute tick and returns the hour tick.
// [R18] Second tick is one pulse every 32768 slow clock cycles.
module watch_buzzer_second_counter
	import watch_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Slow clock pin and power control
	input wire logic slowClock,
	input wire logic slowClockStop,
	// Shared pin
	input wire logic portData,
	output logic tonePin,
	// Minute counter link
	input wire logic hourTick,
	output logic minuteTick,
	output logic secondTick,
	// Interrupts
	output logic watchIrq,
	output logic irq
);
	////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [2:0] slowSync_reg;
	logic [1:0] stopSync_reg;
	logic slowEdge;
	bus_req_type req;

	// Two stages, third stage for the edge detector
	always_ff @(posedge mclk) begin
		if (rst) begin
			slowSync_reg <= '0;
			stopSync_reg <= '0;
		end else if (clkEn) begin
			slowSync_reg <= {slowSync_reg[1:0], slowClock};
			stopSync_reg <= {stopSync_reg[0], slowClockStop};
		end
	end

	assign slowEdge = slowSync_reg[1] & ~slowSync_reg[2];
	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	////////////////////////////////////////////////////////////////
	// Prescaler
	logic [PRESCALER_WIDTH-1:0] presc;
	logic secTickRaw, twoSecTick, clearWrite, prescClear;

	assign clearWrite = req.wr && req.addr == CONTROL_OFFSET && req.wdata[CLEAR_BIT]; // [R05] [R06]
	assign prescClear = clearWrite | stopSync_reg[1]; // [R15]

	slow_prescaler #(
		.WIDTH(PRESCALER_WIDTH)
	) prescaler (
		.mclk(mclk),
		.rst(rst),
		.clkEn(clkEn),
		.slowEdge(slowEdge),
		.clear(prescClear),
		.count(presc),
		.secondTick(secTickRaw), // [R18]
		.twoSecondTick(twoSecTick)
	);

	////////////////////////////////////////////////////////////////
	// Registers
	logic pinEnable_reg, pinEnable_next;
	tone_type tone_reg, tone_next;
	wsrc_type wsrc_reg, wsrc_next;
	logic stable_reg, stable_next;
	logic halt_reg, halt_next;
	logic test_reg, test_next;
	logic [5:0] count_reg, count_next;
	logic [3:0] status_reg, status_next;
	logic [3:0] mask_reg, mask_next;
	logic [7:0] rdata_reg, rdata_next;
	logic minTick, countStep, bit5Fall, watchEvent, stableRise;

	// Second counter step source
	always_comb begin
		countStep = 1'b0;
		if (!halt_reg) begin // [R08]
			countStep = test_reg ? slowEdge : secTickRaw; // [R09]
		end
	end

	assign minTick = countStep && count_reg == SECOND_LAST; // [R12]
	assign bit5Fall = count_reg[5] & ~count_next[5]; // [R13]
	assign stableRise = twoSecTick & ~stable_reg & ~prescClear;

	// Watch interrupt source mux
	always_comb begin
		unique case (wsrc_reg) // [R07]
			WSRC_NONE: watchEvent = 1'b0;
			WSRC_SECOND: watchEvent = secTickRaw | bit5Fall; // [R13]
			WSRC_MINUTE: watchEvent = minTick;
			WSRC_HOUR: watchEvent = hourTick; // [R17]
		endcase
	end

	// Register next values
	always_comb begin
		pinEnable_next = pinEnable_reg;
		tone_next = tone_reg;
		wsrc_next = wsrc_reg;
		halt_next = halt_reg;
		test_next = test_reg;
		count_next = count_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		stable_next = stable_reg;
		// Hardware counting
		if (countStep) begin
			count_next = (count_reg == SECOND_LAST) ? 6'h00 : count_reg + 6'h01; // [R11] [R14]
		end
		// Stable flag
		if (prescClear) begin
			stable_next = 1'b0; // [R05] [R16]
		end else if (twoSecTick) begin
			stable_next = 1'b1; // [R16] [R04]
		end
		// Software writes
		if (req.wr) begin
			unique case (req.addr)
				CONTROL_OFFSET: begin
					pinEnable_next = req.wdata[PIN_ENABLE_BIT];
					tone_next = tone_type'(req.wdata[TONE_SEL_LSB +: 2]);
					wsrc_next = wsrc_type'(req.wdata[IRQ_SEL_LSB +: 2]);
				end
				SECOND_OFFSET: begin
					halt_next = req.wdata[HALT_BIT];
					test_next = req.wdata[TEST_BIT]; // [R10]
					count_next = req.wdata[5:0]; // [R14]
				end
				IRQ_MASK_OFFSET: mask_next = req.wdata[3:0];
				IRQ_STATUS_OFFSET: status_next = status_reg & ~req.wdata[3:0];
				default: ;
			endcase
		end
		// Events set after the clear so set wins
		status_next[EV_WATCH] = status_next[EV_WATCH] | watchEvent;
		status_next[EV_MINUTE] = status_next[EV_MINUTE] | minTick;
		status_next[EV_STABLE] = status_next[EV_STABLE] | stableRise;
		status_next[EV_COUNT] = status_next[EV_COUNT] | countStep;
	end

	// Read data, one cycle after the strobe
	always_comb begin
		rdata_next = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				CONTROL_OFFSET: rdata_next = {pinEnable_reg, tone_reg, stable_reg, 1'b0, wsrc_reg,
					1'b0}; // [R04] [R06]
				SECOND_OFFSET: rdata_next = {halt_reg, test_reg, count_reg};
				IRQ_STATUS_OFFSET: rdata_next = {4'h0, status_reg};
				IRQ_MASK_OFFSET: rdata_next = {4'h0, mask_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// Register storage
	always_ff @(posedge mclk) begin
		if (rst) begin
			pinEnable_reg <= CONTROL_RESET[PIN_ENABLE_BIT];
			tone_reg <= TONE_OFF;
			wsrc_reg <= WSRC_NONE;
			stable_reg <= CONTROL_RESET[STABLE_BIT];
			halt_reg <= SECOND_RESET[HALT_BIT]; // [R08]
			test_reg <= SECOND_RESET[TEST_BIT];
			count_reg <= SECOND_RESET[5:0];
			status_reg <= 4'h0;
			mask_reg <= 4'h0;
			rdata_reg <= 8'h00;
		end else if (clkEn) begin
			pinEnable_reg <= pinEnable_next;
			tone_reg <= tone_next;
			wsrc_reg <= wsrc_next;
			stable_reg <= stable_next;
			halt_reg <= halt_next;
			test_reg <= test_next;
			count_reg <= count_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	logic toneWave, pin_next;
	logic tonePin_reg, minuteTick_reg, secondTick_reg, watchIrq_reg, irq_reg;

	// Tone select
	always_comb begin
		unique case (tone_reg)
			TONE_OFF: toneWave = 1'b0; // [R02]
			TONE_1K: toneWave = presc[TAP_1K]; // [R03]
			TONE_2K: toneWave = presc[TAP_2K]; // [R03]
			TONE_4K: toneWave = presc[TAP_4K]; // [R03]
		endcase
		pin_next = pinEnable_reg ? toneWave : portData; // [R01]
	end

	// Output flops
	always_ff @(posedge mclk) begin
		if (rst) begin
			tonePin_reg <= 1'b0;
			minuteTick_reg <= 1'b0;
			secondTick_reg <= 1'b0;
			watchIrq_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else if (clkEn) begin
			tonePin_reg <= pin_next;
			minuteTick_reg <= minTick; // [R12]
			secondTick_reg <= secTickRaw;
			watchIrq_reg <= watchEvent; // [R13]
			irq_reg <= |(status_next & mask_next);
		end
	end

	assign tonePin = tonePin_reg;
	assign minuteTick = minuteTick_reg;
	assign secondTick = secondTick_reg;
	assign watchIrq = watchIrq_reg;
	assign irq = irq_reg;
	assign rdata = rdata_reg;
endmodule

//--- rtl/watch_pkg.sv
// Package: register map, field layout, reset values and timing constants
package watch_pkg;
	// Register offsets (byte addresses on the register port)
	localparam logic [7:0] CONTROL_OFFSET = 8'ha3;
	localparam logic [7:0] SECOND_OFFSET = 8'ha4;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'ha6;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'ha7;
	// Control field positions
	localparam int PIN_ENABLE_BIT = 7;
	localparam int TONE_SEL_LSB = 5;
	localparam int STABLE_BIT = 4;
	localparam int CLEAR_BIT = 3;
	localparam int IRQ_SEL_LSB = 1;
	// Second register field positions
	localparam int HALT_BIT = 7;
	localparam int TEST_BIT = 6;
	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] SECOND_RESET = 8'h80;
	// Counting constants
	localparam int PRESCALER_WIDTH = 17;
	localparam logic [5:0] SECOND_LAST = 6'h3b;
	// Slow clock edges per second
	localparam logic [16:0] SECOND_MARK = 17'h08000;
	// Tone taps: prescaler bit whose period is 32768/1024 etc.
	localparam int TAP_1K = 4;
	localparam int TAP_2K = 3;
	localparam int TAP_4K = 2;
	// Interrupt status bits
	localparam int EV_WATCH = 0;
	localparam int EV_MINUTE = 1;
	localparam int EV_STABLE = 2;
	localparam int EV_COUNT = 3;

	// Tone frequency codes
	typedef enum logic [1:0] {
		TONE_OFF = 2'b00,
		TONE_1K = 2'b01,
		TONE_2K = 2'b10,
		TONE_4K = 2'b11
	} tone_type;

	// Watch interrupt source codes
	typedef enum logic [1:0] {
		WSRC_NONE = 2'b00,
		WSRC_SECOND = 2'b01,
		WSRC_MINUTE = 2'b10,
		WSRC_HOUR = 2'b11
	} wsrc_type;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;
endpackage
